// ===== logic/rriu_unit.sv
// Rotate and interrupt-return execution unit of a small 8-bit core.
// Assumes the decoder has already read the addressed data byte and
// presents it with the operation, and that the stack top is valid.
//
// Overview of operation
// - Return from interrupt loads the counter from the stack top and sets the master enable, touching no flag.
// - A request pending at that return is serviced before the main program resumes.
// - Rotate left in place writes the byte back rotated left with bit 7 into bit 0, flags kept.
// - Rotate left to work puts that rotation in the working register, memory and flags kept.
// - Rotate left through carry in place writes back the nine-bit left rotation and loads old bit 7 into carry.
// - Rotate left through carry to work puts the nine-bit rotation in the working register and updates carry, memory kept.
// - Rotate right in place writes the byte back rotated right with bit 0 into bit 7, flags kept.
// - Rotate right to work puts that rotation in the working register, memory and flags kept.
// - Rotate right through carry in place writes back the nine-bit right rotation and loads old bit 0 into carry.
`timescale 1ns/1ps
module rriu_unit
  import rriu_pkg::*;
#(
  parameter int DATA_W = RRIU_DATA_W,
  parameter int PC_W   = RRIU_PC_W
) (
  input  wire logic              i_clk,         // Core clock.
  input  wire logic              i_rstn,        // Async reset, low.
  input  wire rriu_req_t         i_req,         // Decoded request.
  input  wire logic [PC_W-1:0]   i_stack_top,   // Top stack entry.
  input  wire logic              i_irq_pending, // Interrupt waiting.
  input  wire logic              i_acc_ld,      // Other unit loads acc.
  input  wire logic [DATA_W-1:0] i_acc_val,     // Value for that load.
  input  wire logic              i_c_ld,        // Other unit loads carry.
  input  wire logic              i_c_val,       // Value for that load.
  input  wire logic              i_mie_clr,     // Clear master enable.
  output logic                   o_ready,       // Request accepted.
  output logic                   o_done,        // Result committed.
  output rriu_mem_t              o_mem,         // Write-back port.
  output logic [DATA_W-1:0]      o_acc,         // Working register.
  output logic                   o_carry,       // Carry flag.
  output logic                   o_mie,         // Master enable.
  output logic                   o_pc_ld,       // Load counter pulse.
  output logic [PC_W-1:0]        o_pc_val,      // Counter value.
  output logic                   o_irq_service  // Enter pending ISR.
);

  // ************************************************************
  // Operation decode
  // ************************************************************
  wire logic take;
  wire logic op_return_from_interrupt;
  wire logic op_left;
  wire logic op_carry;
  wire logic op_in_place;
  wire logic op_to_work;
  wire logic op_rotate;
  wire logic state_is_serv;

  assign take    = o_ready && i_req.valid;
  assign op_return_from_interrupt = (i_req.op == RRIU_OP_RETURN_FROM_INT);
  assign op_left = (i_req.op == RRIU_OP_ROT_LEFT_IN_PLACE)
                || (i_req.op == RRIU_OP_ROT_LEFT_TO_WORK)
                || (i_req.op == RRIU_OP_ROT_LEFT_C_IN_PLACE)
                || (i_req.op == RRIU_OP_ROT_LEFT_C_TO_WORK);
  assign op_carry = (i_req.op == RRIU_OP_ROT_LEFT_C_IN_PLACE)
                 || (i_req.op == RRIU_OP_ROT_LEFT_C_TO_WORK)
                 || (i_req.op == RRIU_OP_ROT_RIGHT_C_IN_PLACE)
                 || (i_req.op == RRIU_OP_ROT_RIGHT_C_TO_WORK);
  assign op_in_place = (i_req.op == RRIU_OP_ROT_LEFT_IN_PLACE)
                    || (i_req.op == RRIU_OP_ROT_LEFT_C_IN_PLACE)
                    || (i_req.op == RRIU_OP_ROT_RIGHT_IN_PLACE)
                    || (i_req.op == RRIU_OP_ROT_RIGHT_C_IN_PLACE);
  assign op_to_work = (i_req.op == RRIU_OP_ROT_LEFT_TO_WORK)
                   || (i_req.op == RRIU_OP_ROT_LEFT_C_TO_WORK)
                   || (i_req.op == RRIU_OP_ROT_RIGHT_TO_WORK)
                   || (i_req.op == RRIU_OP_ROT_RIGHT_C_TO_WORK);
  assign op_rotate = op_in_place || op_to_work;

  // ************************************************************
  // Rotation datapath
  // ************************************************************
  logic [DATA_W-1:0] acc_q;
  logic              carry_q;
  logic              mie_q;
  logic [DATA_W-1:0] rot_data;
  logic              rot_cout;

  rriu_rotator #(
    .W            (DATA_W)
  ) u_rot (
    .i_left       (op_left),
    .i_thru_carry (op_carry),
    .i_data       (i_req.operand),
    .i_cin        (carry_q),
    .o_data       (rot_data),
    .o_cout       (rot_cout)
  );

  // ************************************************************
  // Next-value selection
  // ************************************************************
  // Plain rotates keep wr_c low and leave the rotator's carry unused, so
  // the carry only moves on through-carry forms.
  wire logic              wr_mem;
  wire logic              wr_acc;
  wire logic              wr_c;
  wire logic              do_return_from_interrupt;
  logic [DATA_W-1:0]      acc_d;
  logic                   carry_d;
  logic                   mie_d;

  assign wr_mem  = take && op_in_place;
  assign wr_acc  = take && op_to_work;
  assign wr_c    = take && op_rotate && op_carry;
  assign do_return_from_interrupt = take && op_return_from_interrupt;

  // The unit's own result wins over a load from elsewhere in the
  // same cycle, since the decoder issues one instruction at a time.
  assign acc_d   = wr_acc ? rot_data
                 : (i_acc_ld ? i_acc_val : acc_q);
  assign carry_d = wr_c ? rot_cout
                 : (i_c_ld ? i_c_val : carry_q);
  // Setting the enable wins over a clear in the same cycle.
  assign mie_d   = do_return_from_interrupt ? RRIU_MIE_ON
                 : (state_is_serv || i_mie_clr) ? RRIU_MIE_RST
                 : mie_q;

  // ************************************************************
  // Control state
  // ************************************************************
  rriu_state_t state_q;
  rriu_state_t state_d;
  logic        return_from_interrupt_q;
  wire logic   state_is_idle;
  wire logic   state_is_done;

  assign state_is_idle = (state_q == RRIU_ST_IDLE);
  assign state_is_done = (state_q == RRIU_ST_DONE);
  assign state_is_serv = (state_q == RRIU_ST_SERV);

  always_comb begin
    state_d = state_q;
    case (state_q)
      RRIU_ST_IDLE: begin
        if (take) begin
          state_d = RRIU_ST_DONE;
        end
      end
      RRIU_ST_DONE: begin
        // The pending request is entered before the restored
        // address runs, so the ISR nests on the returned frame.
        if (return_from_interrupt_q && i_irq_pending && mie_q) begin
          state_d = RRIU_ST_SERV;
        end else begin
          state_d = RRIU_ST_IDLE;
        end
      end
      RRIU_ST_SERV: begin
        state_d = RRIU_ST_IDLE;
      end
      default: begin
        state_d = RRIU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= RRIU_ST_IDLE;
      return_from_interrupt_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        return_from_interrupt_q <= op_return_from_interrupt;
      end
    end
  end

  // ************************************************************
  // Architectural registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_q   <= RRIU_ACC_RST;
      carry_q <= RRIU_C_RST;
      mie_q   <= RRIU_MIE_RST;
    end else begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
      mie_q   <= mie_d;
    end
  end

  // ************************************************************
  // Memory write-back and counter load
  // ************************************************************
  logic [DATA_W-1:0] mem_wdata_q;
  logic              mem_we_q;
  logic [PC_W-1:0]   pc_val_q;
  logic              pc_ld_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_we_q    <= 1'b0;
      mem_wdata_q <= '0;
      pc_ld_q     <= 1'b0;
      pc_val_q    <= '0;
    end else begin
      mem_we_q <= wr_mem;
      pc_ld_q  <= do_return_from_interrupt;
      if (wr_mem) begin
        mem_wdata_q <= rot_data;
      end
      if (do_return_from_interrupt) begin
        pc_val_q <= i_stack_top;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_ready       = state_is_idle;
  assign o_done        = state_is_done;
  // One driver for the whole carrier keeps the struct a single variable.
  assign o_mem         = '{we: mem_we_q, wdata: mem_wdata_q};
  assign o_acc         = acc_q;
  assign o_carry       = carry_q;
  assign o_mie         = mie_q;
  assign o_pc_ld       = pc_ld_q;
  assign o_pc_val      = pc_val_q;
  assign o_irq_service = state_is_serv;

endmodule : rriu_unit

// ===== shared/rriu_pkg.sv
// Package for the rotate and interrupt-return unit.
// Assumes the instruction decoder presents one decoded operation at a time.
package rriu_pkg;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int          RRIU_DATA_W  = 8;
  localparam int          RRIU_PC_W    = 11;
  localparam logic [7:0]  RRIU_ACC_RST = 8'h00;
  localparam logic        RRIU_C_RST   = 1'b0;
  localparam logic        RRIU_MIE_RST = 1'b0;
  localparam logic        RRIU_MIE_ON  = 1'b1;

  // ************************************************************
  // Decoded operations
  // ************************************************************
  typedef enum logic [3:0] {
    RRIU_OP_NONE                = 4'h0,
    RRIU_OP_RETURN_FROM_INT     = 4'h1,
    RRIU_OP_ROT_LEFT_IN_PLACE   = 4'h2,
    RRIU_OP_ROT_LEFT_TO_WORK    = 4'h3,
    RRIU_OP_ROT_LEFT_C_IN_PLACE = 4'h4,
    RRIU_OP_ROT_LEFT_C_TO_WORK  = 4'h5,
    RRIU_OP_ROT_RIGHT_IN_PLACE  = 4'h6,
    RRIU_OP_ROT_RIGHT_TO_WORK   = 4'h7,
    RRIU_OP_ROT_RIGHT_C_IN_PLACE = 4'h8,
    RRIU_OP_ROT_RIGHT_C_TO_WORK = 4'h9
  } rriu_op_t;

  // ************************************************************
  // Unit states, one-hot
  // ************************************************************
  typedef enum logic [2:0] {
    RRIU_ST_IDLE = 3'b001,
    RRIU_ST_DONE = 3'b010,
    RRIU_ST_SERV = 3'b100
  } rriu_state_t;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic                   valid;
    rriu_op_t               op;
    logic [RRIU_DATA_W-1:0] operand;
  } rriu_req_t;

  typedef struct packed {
    logic                   we;
    logic [RRIU_DATA_W-1:0] wdata;
  } rriu_mem_t;

endpackage : rriu_pkg

// ===== logic/rriu_rotator.sv
// One-bit rotator, left or right, with or without the carry in the loop.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module rriu_rotator #(
  parameter int W = 8
) (
  input  wire logic         i_left,       // Rotate toward the MSB.
  input  wire logic         i_thru_carry, // Carry joins the loop.
  input  wire logic [W-1:0] i_data,       // Operand byte.
  input  wire logic         i_cin,        // Old carry.
  output logic      [W-1:0] o_data,       // Rotated byte.
  output logic              o_cout        // New carry.
);

  // ************************************************************
  // Fill bits and shifted results
  // ************************************************************
  wire logic         fill_left;
  wire logic         fill_right;
  wire logic [W-1:0] rot_left;
  wire logic [W-1:0] rot_right;

  assign fill_left  = i_thru_carry ? i_cin : i_data[W-1];
  assign fill_right = i_thru_carry ? i_cin : i_data[0];
  assign rot_left   = {i_data[W-2:0], fill_left};
  assign rot_right  = {fill_right, i_data[W-1:1]};

  assign o_data = i_left ? rot_left : rot_right;
  // Without carry in the loop the carry passes through untouched.
  assign o_cout = !i_thru_carry ? i_cin
                : (i_left ? i_data[W-1] : i_data[0]);

endmodule : rriu_rotator

// ===== sim/rriu_unit_properties.sv
// Concurrent checks on the ports of the rotate and interrupt-return unit.
// Assumes one core clock and the unit's asynchronous active-low reset.
`timescale 1ns/1ps
module rriu_unit_properties
  import rriu_pkg::*;
#(
  parameter int DATA_W = RRIU_DATA_W,
  parameter int PC_W   = RRIU_PC_W
) (
  input  wire logic              i_clk,         // Core clock.
  input  wire logic              i_rstn,        // Async reset, low.
  input  wire rriu_req_t         i_req,         // Decoded request.
  input  wire logic [PC_W-1:0]   i_stack_top,   // Top stack entry.
  input  wire logic              i_irq_pending, // Interrupt waiting.
  input  wire logic              i_acc_ld,      // External acc load.
  input  wire logic              i_c_ld,        // External carry load.
  input  wire logic              i_mie_clr,     // Clear enable.
  input  wire logic              o_ready,       // Request accepted.
  input  wire logic              o_done,        // Result committed.
  input  wire rriu_mem_t         o_mem,         // Write-back port.
  input  wire logic [DATA_W-1:0] o_acc,         // Working register.
  input  wire logic              o_carry,       // Carry flag.
  input  wire logic              o_mie,         // Master enable.
  input  wire logic              o_pc_ld,       // Load counter pulse.
  input  wire logic [PC_W-1:0]   o_pc_val,      // Counter value.
  input  wire logic              o_irq_service  // Enter pending ISR.
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // External loads would change registers that the checks expect to hold, so they are excluded.
  logic       take;
  logic       quiet;
  rriu_op_t   op;
  logic [7:0] rl_e;
  logic [7:0] rr_e;
  logic [8:0] rlc9;
  logic [8:0] rrc9;
  assign take  = o_ready && i_req.valid;
  assign quiet = take && !i_c_ld && !i_acc_ld;
  assign op    = i_req.op;
  assign rl_e  = {i_req.operand[6:0], i_req.operand[7]};
  assign rr_e  = {i_req.operand[0], i_req.operand[7:1]};
  assign rlc9  = {i_req.operand, o_carry};
  assign rrc9  = {o_carry, i_req.operand};
  sequence serv_s;
    o_irq_service ##1 (o_ready && !o_mie);
  endsequence
  ret_load_a: assert property (take && op == RRIU_OP_RETURN_FROM_INT |=>
    o_pc_ld && o_mie && o_pc_val == $past(i_stack_top))
    else $error("return did not load the counter");
  ret_flag_a: assert property (quiet && op == RRIU_OP_RETURN_FROM_INT |=>
    $stable(o_carry) && $stable(o_acc) && !o_mem.we)
    else $error("return touched a flag");
  irq_serv_a: assert property (o_pc_ld && i_irq_pending && !i_mie_clr
    |=> serv_s) else $error("pending interrupt not serviced");
  rl_mem_a: assert property (quiet && op == RRIU_OP_ROT_LEFT_IN_PLACE |=>
    o_mem.we && o_mem.wdata == $past(rl_e) && $stable(o_carry))
    else $error("left rotate write-back wrong");
  rl_work_a: assert property (quiet && op == RRIU_OP_ROT_LEFT_TO_WORK |=>
    !o_mem.we && o_acc == $past(rl_e) && $stable(o_carry))
    else $error("left rotate to work wrong");
  rlc_mem_a: assert property (quiet && op == RRIU_OP_ROT_LEFT_C_IN_PLACE
    |=> o_mem.we && {o_carry, o_mem.wdata} == $past(rlc9))
    else $error("left carry rotate write-back wrong");
  rlc_work_a: assert property (quiet && op == RRIU_OP_ROT_LEFT_C_TO_WORK
    |=> !o_mem.we && {o_carry, o_acc} == $past(rlc9))
    else $error("left carry rotate to work wrong");
  rr_mem_a: assert property (quiet && op == RRIU_OP_ROT_RIGHT_IN_PLACE |=>
    o_mem.we && o_mem.wdata == $past(rr_e) && $stable(o_carry))
    else $error("right rotate write-back wrong");
  rr_work_a: assert property (quiet && op == RRIU_OP_ROT_RIGHT_TO_WORK |=>
    !o_mem.we && o_acc == $past(rr_e) && $stable(o_carry))
    else $error("right rotate to work wrong");
  rrc_mem_a: assert property (quiet && op == RRIU_OP_ROT_RIGHT_C_IN_PLACE
    |=> o_mem.we && {o_mem.wdata, o_carry} == $past(rrc9))
    else $error("right carry rotate write-back wrong");
  done_time_a: assert property (take |=> o_done && !o_ready ##1 !o_done)
    else $error("request not completed in one cycle");
  no_stray_a: assert property (!take |=> !o_done && !o_mem.we && !o_pc_ld)
    else $error("result without a taken request");
endmodule : rriu_unit_properties

bind rriu_unit rriu_unit_properties #(.DATA_W(DATA_W), .PC_W(PC_W)) u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_stack_top(i_stack_top),
  .i_irq_pending(i_irq_pending), .i_acc_ld(i_acc_ld), .i_c_ld(i_c_ld),
  .i_mie_clr(i_mie_clr), .o_ready(o_ready), .o_done(o_done), .o_mem(o_mem),
  .o_acc(o_acc), .o_carry(o_carry), .o_mie(o_mie), .o_pc_ld(o_pc_ld),
  .o_pc_val(o_pc_val), .o_irq_service(o_irq_service));

// ===== sim/tb.sv
// Self-checking bench for the rotate and interrupt-return unit.
// Assumes a 50 MHz core clock; inputs move on the falling edge.
`timescale 1ns/1ps
module tb;
  import rriu_pkg::*;
  logic       i_clk         = 1'b0;
  logic       i_rstn        = 1'b0;
  rriu_req_t  i_req         = '0;
  logic [10:0] i_stack_top  = 11'h000;
  logic       i_irq_pending = 1'b0;
  logic       i_acc_ld      = 1'b0;
  logic [7:0] i_acc_val     = 8'h00;
  logic       i_c_ld        = 1'b0;
  logic       i_c_val       = 1'b0;
  logic       i_mie_clr     = 1'b0;
  logic       o_ready, o_done, o_carry, o_mie, o_pc_ld, o_irq_service;
  rriu_mem_t  o_mem;
  logic [7:0] o_acc;
  logic [10:0] o_pc_val;
  int         failures      = 0;
  int         check_count   = 0;
  always #10 i_clk = ~i_clk;
  rriu_unit DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_stack_top(i_stack_top),
    .i_irq_pending(i_irq_pending), .i_acc_ld(i_acc_ld), .i_acc_val(i_acc_val),
    .i_c_ld(i_c_ld), .i_c_val(i_c_val), .i_mie_clr(i_mie_clr),
    .o_ready(o_ready), .o_done(o_done), .o_mem(o_mem), .o_acc(o_acc),
    .o_carry(o_carry), .o_mie(o_mie), .o_pc_ld(o_pc_ld),
    .o_pc_val(o_pc_val), .o_irq_service(o_irq_service));
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [10:0] e,
                     input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Presents one request and returns at the falling edge after it is taken.
  task automatic go(input rriu_op_t op, input logic [7:0] d);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    if (o_ready !== 1'b1) begin
      failures++;
      test_done();
    end
    i_req = '{valid: 1'b1, op: op, operand: d};
    @(negedge i_clk);
    i_req.valid = 1'b0;
  endtask : go
  task automatic t_rot;
    logic [7:0] d, r;
    logic       c, co, lf, th, tw;
    for (int k = 2; k < 10; k++) begin
      for (int j = 0; j < 4; j++) begin
        d = j[1] ? 8'h4e : 8'h81;
        c = j[0];
        @(negedge i_clk);
        i_acc_ld = 1'b1;
        i_acc_val = 8'h5a;
        i_c_ld = 1'b1;
        i_c_val = c;
        @(negedge i_clk);
        i_acc_ld = 1'b0;
        i_c_ld = 1'b0;
        go(rriu_op_t'(k), d);
        lf = k < 6;
        th = k inside {4, 5, 8, 9};
        tw = k inside {3, 5, 7, 9};
        r = lf ? {d[6:0], th ? c : d[7]} : {th ? c : d[0], d[7:1]};
        co = th ? (lf ? d[7] : d[0]) : c;
        chk("done", 1'b1, o_done);
        chk("mem write", !tw, o_mem.we);
        if (!tw) begin
          chk("mem data", r, o_mem.wdata);
        end
        chk("acc", tw ? r : 8'h5a, o_acc);
        chk("carry", co, o_carry);
      end
    end
    $display("rotate test finished");
  endtask : t_rot
  task automatic t_ret;
    @(negedge i_clk);
    i_c_ld = 1'b1;
    i_c_val = 1'b1;
    i_stack_top = 11'h5a3;
    @(negedge i_clk);
    i_c_ld = 1'b0;
    go(RRIU_OP_RETURN_FROM_INT, 8'h00);
    chk("pc load", 1'b1, o_pc_ld);
    chk("pc value", 11'h5a3, o_pc_val);
    chk("enable", 1'b1, o_mie);
    chk("carry kept", 1'b1, o_carry);
    @(negedge i_clk);
    chk("no service", 1'b0, o_irq_service);
    chk("ready", 1'b1, o_ready);
    i_mie_clr = 1'b1;
    @(negedge i_clk);
    i_mie_clr = 1'b0;
    chk("enable cleared", 1'b0, o_mie);
    // Valid stays up through the busy cycles; those edges must be ignored.
    i_stack_top = 11'h7ff;
    i_irq_pending = 1'b1;
    i_req = '{valid: 1'b1, op: RRIU_OP_RETURN_FROM_INT, operand: 8'h00};
    @(negedge i_clk);
    chk("pc value", 11'h7ff, o_pc_val);
    chk("enable", 1'b1, o_mie);
    @(negedge i_clk);
    chk("service", 1'b1, o_irq_service);
    chk("busy", 1'b0, o_ready);
    chk("refused", 1'b0, o_pc_ld);
    @(negedge i_clk);
    chk("isr enable", 1'b0, o_mie);
    chk("ready", 1'b1, o_ready);
    chk("refused", 1'b0, o_done);
    i_req.valid = 1'b0;
    i_irq_pending = 1'b0;
    // An empty operation is still taken and only pulses done.
    @(negedge i_clk);
    go(RRIU_OP_NONE, 8'hff);
    chk("idle op done", 1'b1, o_done);
    chk("idle op write", 1'b0, o_mem.we);
    chk("idle op pc", 1'b0, o_pc_ld);
    $display("return test finished");
  endtask : t_ret
  initial begin
    repeat (8) @(negedge i_clk);
    chk("reset ready", 1'b1, o_ready);
    chk("reset acc", RRIU_ACC_RST, o_acc);
    chk("reset enable", RRIU_MIE_RST, o_mie);
    i_rstn = 1'b1;
    t_rot();
    t_ret();
    test_done();
  end
endmodule : tb
